// >>> src/oag_addr_gen.sv
/*
   Operand and branch-target address generator for an 8-bit CPU.
   Assumes the CPU presents an already fetched instruction with its
   operand bytes, index register and program counter in one cycle;
   pc is the address of the opcode. Results appear one cycle later.
*/
`timescale 1ns/100ps

// Function
// [RULE1] Inherent instructions are one byte and form no operand address.
// [RULE2] Immediate instructions are two bytes and hand the literal byte on with no address.
// [RULE3] Direct instructions are two bytes, the second byte low and the high byte zero.
// [RULE4] Bit test and branch is three bytes, direct operand via byte two, relative via byte three.
// [RULE5] Extended instructions are three bytes, byte two high and byte three low address.
// [RULE6] Indexed no offset is one byte, index low and high zero, within 0000 to 00FF.
// [RULE7] Indexed 8-bit offset is two bytes, unsigned index plus byte, up to 01FE.
// [RULE8] Indexed 16-bit offset is three bytes, index plus offset given high byte first.
// [RULE9] Relative addressing is for branches, taken adds the byte, else the next instruction.
// [RULE10] The displacement is two's complement from the next address, reach -128 to +127.
// [RULE11] The 16-bit indexed sum wraps modulo the 16-bit address space.
module oag_addr_gen (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             req_valid,
   input  wire oag_pkg::oag_req_t req,
   output logic                  rsp_valid,
   output oag_pkg::oag_rsp_t     rsp
);
   import oag_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_s1_q;
   logic rst_s2_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic     [15:0] rel_target;
   logic     [15:0] rel_base;
   logic     [7:0]  rel_disp;
   logic     [16:0] ix2_sum;
   oag_rsp_t        rsp_d;
   oag_rsp_t        rsp_q;
   logic            rsp_valid_d;
   logic            rsp_valid_q;

   oag_rel_adder u_rel (
      .base   (rel_base),
      .disp   (rel_disp),
      .target (rel_target)
   );

   always_comb begin
      rsp_d       = '0;
      rel_base    = req.pc;
      rel_disp    = req.op1;
      ix2_sum     = {1'b0, req.op1, req.op2} + {9'h000, req.index};
      rsp_valid_d = req_valid;
      case (req.mode)
         OAG_INH: begin
            rsp_d.length = OAG_LEN_ONE;                                  // see [RULE1]
         end
         OAG_IMM: begin
            rsp_d.length    = OAG_LEN_TWO;                               // see [RULE2]
            rsp_d.imm_valid = 1'b1;                                      // see [RULE2]
            rsp_d.imm       = req.op1;
         end
         OAG_DIR: begin
            rsp_d.ea_valid = 1'b1;
            rsp_d.ea       = {OAG_PAGE0_HI, req.op1};                    // see [RULE3]
            if (req.bit_branch) begin
               rsp_d.length = OAG_LEN_THREE;                             // see [RULE4]
               rel_disp     = req.op2;                                   // see [RULE4]
            end else begin
               rsp_d.length = OAG_LEN_TWO;                               // see [RULE3]
            end
         end
         OAG_EXT: begin
            rsp_d.length   = OAG_LEN_THREE;                              // see [RULE5]
            rsp_d.ea_valid = 1'b1;
            rsp_d.ea       = {req.op1, req.op2};                         // see [RULE5]
         end
         OAG_IX0: begin
            rsp_d.length   = OAG_LEN_ONE;                                // see [RULE6]
            rsp_d.ea_valid = 1'b1;
            rsp_d.ea       = {OAG_PAGE0_HI, req.index};                  // see [RULE6]
         end
         OAG_IX1: begin
            rsp_d.length   = OAG_LEN_TWO;                                // see [RULE7]
            rsp_d.ea_valid = 1'b1;
            rsp_d.ea       = {8'h00, req.op1} + {8'h00, req.index};      // see [RULE7]
         end
         OAG_IX2: begin
            rsp_d.length   = OAG_LEN_THREE;                              // see [RULE8]
            rsp_d.ea_valid = 1'b1;
            rsp_d.ea       = ix2_sum[15:0];                              // see [RULE11]
         end
         OAG_REL: begin
            rsp_d.length = OAG_LEN_TWO;                                  // see [RULE9]
         end
         default: begin
            rsp_d.length = OAG_LEN_ONE;
         end
      endcase
      rsp_d.next_pc = req.pc + {14'h0000, rsp_d.length};
      rel_base      = rsp_d.next_pc;                                     // see [RULE10]
      if (req.mode == OAG_REL || (req.mode == OAG_DIR && req.bit_branch)) begin
         rsp_d.target = rel_target;                                      // see [RULE10]
         rsp_d.taken  = req.cond;                                        // see [RULE9]
      end else begin
         rsp_d.target = rsp_d.next_pc;
      end
   end

   always_ff @(posedge clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         rsp_q       <= '0;
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_q       <= rsp_d;
         rsp_valid_q <= rsp_valid_d;
      end
   end

   assign rsp       = rsp_q;
   assign rsp_valid = rsp_valid_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   inh_no_addr_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE1]
      req_valid && req.mode == OAG_INH |=> !rsp.ea_valid && rsp.length == 2'h1)
      else $error("inherent produced an address or wrong length");

   imm_pass_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE2]
      req_valid && req.mode == OAG_IMM |=>
         !rsp.ea_valid && rsp.imm_valid && rsp.imm == $past(req.op1) && rsp.length == 2'h2)
      else $error("immediate decode wrong");

   dir_page0_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE3]
      req_valid && req.mode == OAG_DIR |=>
         rsp.ea == {8'h00, $past(req.op1)} && rsp.ea_valid)
      else $error("direct address wrong");

   bit_branch_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE4]
      req_valid && req.mode == OAG_DIR && req.bit_branch |=> rsp.length == 2'h3
         && rsp.target == $past(req.pc) + 16'h0003 + {{8{$past(req.op2[7])}}, $past(req.op2)})
      else $error("bit branch decode wrong");

   ext_order_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE5]
      req_valid && req.mode == OAG_EXT |=>
         rsp.ea == {$past(req.op1), $past(req.op2)} && rsp.length == 2'h3)
      else $error("extended address wrong");

   ix0_page0_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE6]
      req_valid && req.mode == OAG_IX0 |=> rsp.ea <= 16'h00FF && rsp.length == 2'h1)
      else $error("indexed no offset out of page");

   ix1_sum_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE7]
      req_valid && req.mode == OAG_IX1 |=> rsp.ea <= 16'h01FE
         && rsp.ea == {8'h00, $past(req.op1)} + {8'h00, $past(req.index)})
      else $error("indexed 8-bit sum wrong");

   ix2_wrap_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE8]
      req_valid && req.mode == OAG_IX2 |=>
         rsp.ea == 16'({$past(req.op1), $past(req.op2)} + {8'h00, $past(req.index)}))
      else $error("indexed 16-bit sum wrong");

   rel_taken_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE9]
      req_valid && req.mode == OAG_REL |=> rsp.taken == $past(req.cond)
         && rsp.next_pc == $past(req.pc) + 16'h0002)
      else $error("branch decision wrong");

   rel_span_a: assert property (@(posedge clk) disable iff (!rst_s2_q) // see [RULE10]
      rsp_valid && rsp.taken |-> (rsp.target - rsp.next_pc) <= 16'h007F
         || (rsp.target - rsp.next_pc) >= 16'hFF80)
      else $error("branch reach out of span");

   ext_seen_c: cover property (@(posedge clk) req_valid && req.mode == OAG_EXT);
   taken_back_c: cover property (@(posedge clk) rsp_valid && rsp.taken && rsp.target < rsp.next_pc);
   ix2_wrap_c: cover property (@(posedge clk) req_valid && req.mode == OAG_IX2 && ix2_sum[16]);
   bit_br_c: cover property (@(posedge clk) req_valid && req.mode == OAG_DIR && req.bit_branch);

endmodule // oag_addr_gen

// >>> src/oag_pkg.sv
/*
   Package for the operand address generator: addressing modes, fixed
   address parts, instruction lengths and the carrier structs.
   Assumes a 16-bit address space and an 8-bit data path.
*/
package oag_pkg;

   // ----------------------------------------------------------------
   // Modes and widths
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      OAG_INH,
      OAG_IMM,
      OAG_DIR,
      OAG_EXT,
      OAG_IX0,
      OAG_IX1,
      OAG_IX2,
      OAG_REL
   } oag_mode_t;

   localparam int          OAG_AW         = 16;
   localparam logic [7:0]  OAG_PAGE0_HI   = 8'h00;
   localparam logic [15:0] OAG_RST_ADDR   = 16'h0000;
   localparam logic [1:0]  OAG_LEN_ONE    = 2'h1;
   localparam logic [1:0]  OAG_LEN_TWO    = 2'h2;
   localparam logic [1:0]  OAG_LEN_THREE  = 2'h3;
   localparam logic [1:0]  OAG_LEN_RST    = 2'h0;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      oag_mode_t   mode;
      logic        bit_branch;
      logic        cond;
      logic [7:0]  op1;
      logic [7:0]  op2;
      logic [7:0]  index;
      logic [15:0] pc;
   } oag_req_t;

   typedef struct packed {
      logic        ea_valid;
      logic [15:0] ea;
      logic        imm_valid;
      logic [7:0]  imm;
      logic [1:0]  length;
      logic        taken;
      logic [15:0] next_pc;
      logic [15:0] target;
   } oag_rsp_t;

endpackage

// >>> src/oag_rel_adder.sv
/*
   Relative branch target adder: next address plus a signed byte.
   Assumes combinational use by the address generator on one clock.
*/
`timescale 1ns/100ps

module oag_rel_adder (
   input  wire logic [15:0] base,
   input  wire logic [7:0]  disp,
   output logic      [15:0] target
);
   import oag_pkg::*;

   // ----------------------------------------------------------------
   // Sign extend and add
   // ----------------------------------------------------------------
   always_comb begin
      target = base + {{8{disp[7]}}, disp};
   end

endmodule // oag_rel_adder

// >>> verification/oag_mem_model.sv
/*
   Behavioural memory seen through the generated operand address.
   Assumes a read is selected by a valid address; released data toggles.
*/
`timescale 1ns/100ps

module oag_mem_model (
   input  wire logic        clk,
   input  wire logic        sel,
   input  wire logic [15:0] addr,
   output logic      [7:0]  rd_data
);
   // Selected: data pattern from address; released: inverse of last value
   always_ff @(posedge clk) begin
      rd_data <= sel ? (addr[7:0] ^ addr[15:8]) : ~rd_data;
   end
endmodule // oag_mem_model

// >>> verification/tb_operand_address_generator.sv
/*
   Self-checking bench for the operand address generator: corner cases,
   then LFSR-driven requests. Assumes each answer comes one cycle later.
*/
`timescale 1ns/100ps

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_operand_address_generator;
   import oag_pkg::*;
   logic        clk         = 1'b0;
   logic        rst_b       = 1'b0;
   logic        req_valid   = 1'b0;
   oag_req_t    req         = '0;
   logic        rsp_valid;
   oag_rsp_t    rsp;
   logic [7:0]  mem_data;
   logic [31:0] lfsr        = 32'h00011837;
   int          n_fail      = 0;
   int          comparisons = 0;
   oag_rsp_t    exp_q       = '0;
   logic        vld_q       = 1'b0;
   oag_req_t    r;
   oag_req_t    corner [8];

   always #2.5 clk = ~clk;

   oag_addr_gen u_dut (
      .clk       (clk),
      .rst_b     (rst_b),
      .req_valid (req_valid),
      .req       (req),
      .rsp_valid (rsp_valid),
      .rsp       (rsp)
   );

   oag_mem_model u_mem (
      .clk     (clk),
      .sel     (rsp_valid & rsp.ea_valid),
      .addr    (rsp.ea),
      .rd_data (mem_data)
   );

   // ----------------------------------------------------------------
   // Expected answer
   // ----------------------------------------------------------------
   function automatic oag_rsp_t expect_rsp(input oag_req_t q);
      oag_rsp_t    e;
      logic [15:0] d;
      logic        br;
      e  = '0;
      d  = {{8{q.op1[7]}}, q.op1};
      br = (q.mode == OAG_REL);
      case (q.mode)
         OAG_INH: e.length = OAG_LEN_ONE;
         OAG_IMM: begin
            e = '{length: OAG_LEN_TWO, imm_valid: 1'b1, imm: q.op1, default: '0};
         end
         OAG_DIR: begin
            e.length   = q.bit_branch ? OAG_LEN_THREE : OAG_LEN_TWO;
            e.ea_valid = 1'b1;
            e.ea       = {OAG_PAGE0_HI, q.op1};
            br         = q.bit_branch;
            d          = {{8{q.op2[7]}}, q.op2};
         end
         OAG_EXT: e = '{ea_valid: 1'b1, ea: {q.op1, q.op2}, length: OAG_LEN_THREE, default: '0};
         OAG_IX0: e = '{ea_valid: 1'b1, ea: {8'h00, q.index}, length: OAG_LEN_ONE, default: '0};
         OAG_IX1: begin
            e = '{ea_valid: 1'b1, ea: {8'h00, q.index} + {8'h00, q.op1}, length: OAG_LEN_TWO,
                  default: '0};
         end
         OAG_IX2: begin
            e = '{ea_valid: 1'b1, ea: {q.op1, q.op2} + {8'h00, q.index}, length: OAG_LEN_THREE,
                  default: '0};
         end
         default: e.length = OAG_LEN_TWO;
      endcase
      e.taken   = br & q.cond;
      e.next_pc = q.pc + {14'h0000, e.length};
      e.target  = br ? e.next_pc + d : e.next_pc;
      return e;
   endfunction

   // ----------------------------------------------------------------
   // Drive one request and check the previous answer
   // ----------------------------------------------------------------
   task automatic step(input logic v, input oag_req_t q);
      @(negedge clk);
      `CHK("rsp_valid", vld_q, rsp_valid)
      if (vld_q) begin
         `CHK("length", exp_q.length, rsp.length)
         `CHK("ea", {exp_q.ea_valid, exp_q.ea}, {rsp.ea_valid, rsp.ea})
         `CHK("imm", {exp_q.imm_valid, exp_q.imm}, {rsp.imm_valid, rsp.imm})
         `CHK("branch", {exp_q.taken, exp_q.target}, {rsp.taken, rsp.target})
         `CHK("next_pc", exp_q.next_pc, rsp.next_pc)
      end
      req_valid = v;
      req       = q;
      vld_q     = v;
      exp_q     = expect_rsp(q);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #20000;
      n_fail++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      corner[0] = '{OAG_IX1, 1'b0, 1'b0, 8'hFF, 8'h00, 8'hFF, 16'h0100};
      corner[1] = '{OAG_IX2, 1'b0, 1'b0, 8'hFF, 8'hFF, 8'hFF, 16'hFFFE};
      corner[2] = '{OAG_REL, 1'b0, 1'b1, 8'h80, 8'h00, 8'h00, 16'h0002};
      corner[3] = '{OAG_REL, 1'b0, 1'b1, 8'h7F, 8'h00, 8'h00, 16'hFFF0};
      corner[4] = '{OAG_DIR, 1'b1, 1'b1, 8'hA5, 8'h80, 8'h00, 16'h0200};
      corner[5] = '{OAG_DIR, 1'b1, 1'b0, 8'h5A, 8'h7F, 8'h00, 16'h0300};
      corner[6] = '{OAG_IX0, 1'b0, 1'b0, 8'h00, 8'h00, 8'hFF, 16'h0400};
      corner[7] = '{OAG_INH, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'hFF, 16'h0500};
      repeat (6) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      repeat (3) @(posedge clk);
      foreach (corner[i]) step(1'b1, corner[i]);
      for (int i = 0; i < 400; i++) begin
         lfsr         = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         r.mode       = oag_mode_t'(lfsr[2:0]);
         r.bit_branch = lfsr[3];
         r.cond       = lfsr[4];
         r.op1        = lfsr[12:5];
         r.op2        = lfsr[20:13];
         r.index      = lfsr[28:21];
         r.pc         = lfsr[31:16];
         step(lfsr[30] | lfsr[29], r);
      end
      step(1'b1, corner[1]);
      @(negedge clk) rst_b = 1'b0;
      #1;
      `CHK("reset rsp", {1'b0, 74'h0}, {rsp_valid, rsp})
      end_of_test();
   end
endmodule // tb_operand_address_generator
